// ===== hw/spi_port_params.svh
// constants of the byte-wide serial peripheral port and its far end
// How it works
// - bytes shift most significant bit first
// - master starts transfers and drives the clock
// - single wire needs both data pins tied
// - four clock timing modes, both ends equal
// - done flag bit 7 sets, may interrupt
// - done clears by status then data access
// - data writes ignored until status read
// - collision flag bit 6 on busy write
// - overrun bit 5, cleared by status read
// - mode fault bit 4 on select low
// - fault clears by control access then write
// - output disable bit 2 releases data output
// - soft select bit 1 ignores select pin
// - select level bit 0: zero selects
// - software writes zero to bit 3
// - master data write starts a byte
// - received byte buffered, reads return buffer
// - data write loads shift register directly
// - select input acts as chip select
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

`define CLK_PERIOD_NS 4
`define CTRL_OFF 8'h00
`define CSR_OFF 8'h04
`define DATA_OFF 8'h08
`define CSR_RESET 8'h00
`define CTRL_RESET 8'h00
`define CSR_DONE_BIT 7
`define CSR_WRITE_COLLISION_FLAG_BIT 6
`define CSR_OVR_BIT 5
`define CSR_MODE_FAULT_FLAG_BIT 4
`define CSR_RSVD_BIT 3
`define CSR_ODIS_BIT 2
`define CSR_SSM_BIT 1
`define CSR_SSI_BIT 0
`define CTRL_IRQ_EN_BIT 7
`define CTRL_PE_BIT 6
`define CTRL_MASTER_BIT 4
`define CTRL_CPOL_BIT 3
`define CTRL_CPHA_BIT 2
`define CTRL_RATE_LSB 0
// shortest half period of a clock the device makes
`define MIN_HALF_NS 32
`define MIN_HALF_CYC ((`MIN_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// half period of the clock the far end makes
`define FAR_HALF_NS 40
`define FAR_HALF_CYC (`FAR_HALF_NS / `CLK_PERIOD_NS)
`define BITS_PER_BYTE 8
`define EDGES_PER_BYTE 16

`endif

// ===== hw/spi_port_pkg.sv
// types shared by both ends of the serial port
`default_nettype none
package spi_port_pkg;
	typedef enum logic {XFER_IDLE, XFER_RUN} xfer_e;

	// pin filter: a new level counts once stages two and three agree
	function automatic logic [2:0] settle(input logic [2:0] s2,
		input logic [2:0] s3, input logic [2:0] old);
		settle = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & old);
	endfunction
endpackage
`default_nettype wire

// ===== hw/spi_link_if.sv
// serial link between the port and its far end
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
	logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
	logic dev_miso_o, dev_miso_oe;
	logic far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe;
	logic far_miso_o, far_miso_oe, far_ss_n_o, far_ss_n_oe;
	logic sck, mosi, miso, ss_n;
	// undriven lines rest at their pull levels
	assign sck = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b0);
	assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b1);
	assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe ? far_miso_o : 1'b1);
	assign ss_n = far_ss_n_oe ? far_ss_n_o : 1'b1;
	modport dev (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
		dev_miso_o, dev_miso_oe, input sck, mosi, miso, ss_n);
	modport far (output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe,
		far_miso_o, far_miso_oe, far_ss_n_o, far_ss_n_oe,
		input sck, mosi, miso);
endinterface
`default_nettype wire

// ===== hw/spi_port_device.sv
// serial peripheral port with its register slave on apb
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_params.svh"
module spi_port_device (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	spi_link_if.dev link
);
	logic [2:0] s1, s2, s3, filt, next_filt;
	logic irq_en, peripheral_enable, mstr, cpol, cpha;
	logic [1:0] rate;
	logic transfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag, odis, select_soft_manage, select_soft_level;
	logic transfer_done_flag_arm, csr_rd_seen, mode_fault_flag_arm;
	logic [7:0] sr, rxbuf;
	logic out_bit, sck_q, sck_prev;
	logic [3:0] cnt;
	logic [4:0] edges;
	logic [7:0] div;
	spi_port_pkg::xfer_e st;
	logic next_irq_en, next_spe, next_mstr, next_cpol, next_cpha;
	logic [1:0] next_rate;
	logic next_transfer_done_flag, next_write_collision_flag, next_ovr, next_mode_fault_flag, next_odis;
	logic next_ssm, next_ssi, next_transfer_done_flag_arm, next_csr_rd_seen;
	logic next_mode_fault_flag_arm, next_out_bit, next_sck_q, next_irq;
	logic [7:0] next_sr, next_rxbuf, next_div, half;
	logic [3:0] next_cnt;
	logic [4:0] next_edges;
	logic [31:0] next_prdata;
	spi_port_pkg::xfer_e next_st;
	logic acc, wr, rd, hit_ctrl, hit_csr, hit_data;
	logic ss_int, sel, edge_ev, lead, sample, shift_ev, done;
	logic [7:0] csr_val, ctrl_val;

	assign acc = psel & penable;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign hit_ctrl = paddr == `CTRL_OFF;
	assign hit_csr = paddr == `CSR_OFF;
	assign hit_data = paddr == `DATA_OFF;
	assign pready = 1'b1;
	assign pslverr = acc & ~(hit_ctrl | hit_csr | hit_data);
	assign csr_val = {transfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag, 1'b0, odis, select_soft_manage, select_soft_level};
	assign ctrl_val = {irq_en, peripheral_enable, 1'b0, mstr, cpol, cpha, rate};
	assign ss_int = select_soft_manage ? select_soft_level : filt[2];
	assign sel = peripheral_enable & ~mstr & ~ss_int;
	// at the shortest half period the far end's answer, passing both pin
	// filters, lands after the sampling edge: a master needs rate 1 or more
	assign half = 8'(`MIN_HALF_CYC) << rate;

	// master drives the clock; a slave only follows it
	assign link.dev_sck_o = sck_q;
	assign link.dev_sck_oe = peripheral_enable & mstr;
	assign link.dev_mosi_o = out_bit;
	assign link.dev_mosi_oe = peripheral_enable & mstr & ~odis;
	assign link.dev_miso_o = out_bit;
	assign link.dev_miso_oe = sel & ~odis;

	always_comb begin
		next_filt = spi_port_pkg::settle(s2, s3, filt);
		next_irq_en = irq_en;
		next_spe = peripheral_enable;
		next_mstr = mstr;
		next_cpol = cpol;
		next_cpha = cpha;
		next_rate = rate;
		next_transfer_done_flag = transfer_done_flag;
		next_write_collision_flag = write_collision_flag;
		next_ovr = overrun_flag;
		next_mode_fault_flag = mode_fault_flag;
		next_odis = odis;
		next_ssm = select_soft_manage;
		next_ssi = select_soft_level;
		next_transfer_done_flag_arm = transfer_done_flag_arm;
		next_csr_rd_seen = csr_rd_seen;
		next_mode_fault_flag_arm = mode_fault_flag_arm;
		next_sr = sr;
		next_rxbuf = rxbuf;
		next_out_bit = out_bit;
		next_sck_q = sck_q;
		next_cnt = cnt;
		next_edges = edges;
		next_div = div;
		next_st = st;
		next_prdata = prdata;
		done = 1'b0;
		edge_ev = 1'b0;
		lead = 1'b0;
		// read data is latched in the setup cycle, before side effects
		if (psel & ~penable & ~pwrite) begin
			next_prdata = 32'h00000000;
			if (hit_ctrl)
				next_prdata[7:0] = ctrl_val;
			if (hit_csr)
				next_prdata[7:0] = csr_val;
			if (hit_data)
				next_prdata[7:0] = rxbuf;
		end
		// clearing sequences first; hardware sets below win
		if (acc & hit_csr) begin
			if (transfer_done_flag | write_collision_flag)
				next_transfer_done_flag_arm = 1'b1;
			if (rd) begin
				next_csr_rd_seen = 1'b1;
				next_ovr = 1'b0;
			end
			if (wr) begin
				// bit 3 is kept zero whatever is written
				next_odis = pwdata[`CSR_ODIS_BIT];
				next_ssm = pwdata[`CSR_SSM_BIT];
				next_ssi = pwdata[`CSR_SSI_BIT];
			end
		end
		if (acc & hit_ctrl) begin
			if (mode_fault_flag)
				next_mode_fault_flag_arm = 1'b1;
			if (wr) begin
				next_irq_en = pwdata[`CTRL_IRQ_EN_BIT];
				next_spe = pwdata[`CTRL_PE_BIT];
				next_mstr = pwdata[`CTRL_MASTER_BIT];
				next_cpol = pwdata[`CTRL_CPOL_BIT];
				next_cpha = pwdata[`CTRL_CPHA_BIT];
				next_rate = pwdata[`CTRL_RATE_LSB +: 2];
				if (mode_fault_flag_arm) begin
					next_mode_fault_flag = 1'b0;
					next_mode_fault_flag_arm = 1'b0;
				end
			end
		end
		if (acc & hit_data & transfer_done_flag_arm) begin
			next_transfer_done_flag = 1'b0;
			next_write_collision_flag = 1'b0;
			next_transfer_done_flag_arm = 1'b0;
			next_csr_rd_seen = 1'b0;
		end
		if (wr & hit_data & ~(transfer_done_flag & ~csr_rd_seen)) begin
			if (st == spi_port_pkg::XFER_RUN) begin
				next_write_collision_flag = 1'b1;
			end else begin
				// no transmit buffer: the byte goes straight out
				next_sr = pwdata[7:0];
				next_out_bit = pwdata[7];
				if (peripheral_enable & mstr) begin
					next_st = spi_port_pkg::XFER_RUN;
					next_div = 8'h00;
					next_edges = 5'h00;
					next_sck_q = cpol;
				end
			end
		end
		// clock edges: made here as master, found on the pin as slave
		if (mstr) begin
			if (st == spi_port_pkg::XFER_RUN) begin
				next_div = div + 8'h01;
				if (div == half - 8'h01) begin
					next_div = 8'h00;
					edge_ev = 1'b1;
					lead = sck_q == cpol;
					next_sck_q = ~sck_q;
					next_edges = edges + 5'h01;
				end
			end else begin
				// idle clock follows its polarity: no stray edge at start
				next_sck_q = cpol;
			end
		end else if (sel) begin
			edge_ev = filt[0] != sck_prev;
			lead = sck_prev == cpol;
		end
		sample = edge_ev & (lead != cpha);
		shift_ev = edge_ev & (lead == cpha);
		if (sample) begin
			next_sr = {sr[6:0], filt[1]};
			next_cnt = cnt + 4'h1;
			if (~mstr)
				next_st = spi_port_pkg::XFER_RUN;
		end
		if (shift_ev)
			next_out_bit = sr[7];
		if (mstr)
			done = edge_ev & (edges == 5'(`EDGES_PER_BYTE - 1));
		else
			done = sample & (cnt == 4'(`BITS_PER_BYTE - 1));
		if (done) begin
			next_st = spi_port_pkg::XFER_IDLE;
			next_cnt = 4'h0;
			if (transfer_done_flag) begin
				next_ovr = 1'b1;
			end else begin
				next_rxbuf = next_sr;
				next_transfer_done_flag = 1'b1;
				// an older status read must not unlock data writes
				next_csr_rd_seen = 1'b0;
			end
		end
		if (~mstr & ~sel) begin
			// an idle slave keeps its counter cleared
			next_cnt = 4'h0;
			next_st = spi_port_pkg::XFER_IDLE;
		end
		if (peripheral_enable & mstr & ~ss_int) begin
			// another master pulled select low: stand down
			next_mode_fault_flag = 1'b1;
			next_mstr = 1'b0;
			next_spe = 1'b0;
			next_st = spi_port_pkg::XFER_IDLE;
			next_cnt = 4'h0;
		end
		next_irq = next_irq_en & (next_transfer_done_flag | next_ovr | next_mode_fault_flag);
	end

	always_ff @(posedge clk) begin
		s1 <= {link.ss_n, mstr ? link.miso : link.mosi, link.sck};
		s2 <= s1;
		s3 <= s2;
		if (!nrst) begin
			filt <= 3'h6;
			sck_prev <= 1'b0;
			{irq_en, peripheral_enable, mstr, cpol, cpha, rate} <= 7'h00;
			{transfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag, odis, select_soft_manage, select_soft_level} <= 7'h00;
			{transfer_done_flag_arm, csr_rd_seen, mode_fault_flag_arm} <= 3'h0;
			sr <= 8'h00;
			rxbuf <= 8'h00;
			out_bit <= 1'b0;
			sck_q <= 1'b0;
			cnt <= 4'h0;
			edges <= 5'h00;
			div <= 8'h00;
			st <= spi_port_pkg::XFER_IDLE;
			prdata <= 32'h00000000;
			irq <= 1'b0;
		end else begin
			filt <= next_filt;
			sck_prev <= filt[0];
			irq_en <= next_irq_en;
			peripheral_enable <= next_spe;
			mstr <= next_mstr;
			cpol <= next_cpol;
			cpha <= next_cpha;
			rate <= next_rate;
			transfer_done_flag <= next_transfer_done_flag;
			write_collision_flag <= next_write_collision_flag;
			overrun_flag <= next_ovr;
			mode_fault_flag <= next_mode_fault_flag;
			odis <= next_odis;
			select_soft_manage <= next_ssm;
			select_soft_level <= next_ssi;
			transfer_done_flag_arm <= next_transfer_done_flag_arm;
			csr_rd_seen <= next_csr_rd_seen;
			mode_fault_flag_arm <= next_mode_fault_flag_arm;
			sr <= next_sr;
			rxbuf <= next_rxbuf;
			out_bit <= next_out_bit;
			sck_q <= next_sck_q;
			cnt <= next_cnt;
			edges <= next_edges;
			div <= next_div;
			st <= next_st;
			prdata <= next_prdata;
			irq <= next_irq;
		end
	end
endmodule // spi_port_device
`default_nettype wire

// ===== hw/spi_port_far.sv
// far end of the link: a plain serial master or slave
`timescale 1ns/1ps
`default_nettype none
`include "spi_port_params.svh"
module spi_port_far #(
	parameter int HALF_CYC = `FAR_HALF_CYC
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic master_mode,
	input wire logic cpol,
	input wire logic cpha,
	input wire logic slave_select,
	input wire logic start,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic done,
	output logic busy,
	spi_link_if.far link
);
	logic [2:0] s1, s2, s3, filt;
	logic [7:0] sr, next_sr, next_rx_byte, div, next_div;
	logic out_bit, next_out_bit, sck_q, next_sck_q, sck_prev, next_done;
	logic [3:0] cnt, next_cnt;
	logic [4:0] edges, next_edges;
	spi_port_pkg::xfer_e st, next_st;
	logic edge_ev, lead, sample, fin;

	assign busy = st == spi_port_pkg::XFER_RUN;
	assign link.far_sck_o = sck_q;
	assign link.far_sck_oe = master_mode;
	assign link.far_mosi_o = out_bit;
	assign link.far_mosi_oe = master_mode;
	assign link.far_miso_o = out_bit;
	assign link.far_miso_oe = ~master_mode & slave_select;
	// select held low from the start until the last clock edge, rising in the same cycle as that edge
	assign link.far_ss_n_o = ~busy;
	assign link.far_ss_n_oe = master_mode;

	always_comb begin
		next_sr = sr;
		next_rx_byte = rx_byte;
		next_div = div;
		next_out_bit = out_bit;
		next_sck_q = sck_q;
		next_cnt = cnt;
		next_edges = edges;
		next_st = st;
		edge_ev = 1'b0;
		lead = 1'b0;
		// an idle clock rests at its polarity, so no stray edge leads a frame
		if (~busy)
			next_sck_q = cpol;
		if (start & ~busy) begin
			next_sr = tx_byte;
			next_out_bit = tx_byte[7];
			next_cnt = 4'h0;
			next_edges = 5'h00;
			next_div = 8'h00;
			next_sck_q = cpol;
			if (master_mode)
				next_st = spi_port_pkg::XFER_RUN;
		end
		if (master_mode) begin
			if (busy) begin
				next_div = div + 8'h01;
				if (div == 8'(HALF_CYC - 1)) begin
					next_div = 8'h00;
					edge_ev = 1'b1;
					lead = sck_q == cpol;
					next_sck_q = ~sck_q;
					next_edges = edges + 5'h01;
				end
			end
		end else if (slave_select) begin
			edge_ev = filt[0] != sck_prev;
			lead = sck_prev == cpol;
		end
		sample = edge_ev & (lead != cpha);
		if (sample) begin
			next_sr = {sr[6:0], filt[1]};
			next_cnt = cnt + 4'h1;
			if (~master_mode)
				next_st = spi_port_pkg::XFER_RUN;
		end
		if (edge_ev & (lead == cpha))
			next_out_bit = sr[7];
		if (master_mode)
			fin = edge_ev & (edges == 5'(`EDGES_PER_BYTE - 1));
		else
			fin = sample & (cnt == 4'(`BITS_PER_BYTE - 1));
		next_done = fin;
		if (fin) begin
			next_rx_byte = next_sr;
			next_st = spi_port_pkg::XFER_IDLE;
			next_cnt = 4'h0;
		end
		if (~master_mode & ~slave_select) begin
			next_cnt = 4'h0;
			next_st = spi_port_pkg::XFER_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		s1 <= {1'b1, master_mode ? link.miso : link.mosi, link.sck};
		s2 <= s1;
		s3 <= s2;
		if (!nrst) begin
			filt <= 3'h6;
			sck_prev <= 1'b0;
			sr <= 8'h00;
			rx_byte <= 8'h00;
			div <= 8'h00;
			out_bit <= 1'b0;
			sck_q <= 1'b0;
			cnt <= 4'h0;
			edges <= 5'h00;
			st <= spi_port_pkg::XFER_IDLE;
			done <= 1'b0;
		end else begin
			filt <= spi_port_pkg::settle(s2, s3, filt);
			sck_prev <= filt[0];
			sr <= next_sr;
			rx_byte <= next_rx_byte;
			div <= next_div;
			out_bit <= next_out_bit;
			sck_q <= next_sck_q;
			cnt <= next_cnt;
			edges <= next_edges;
			st <= next_st;
			done <= next_done;
		end
	end
endmodule // spi_port_far
`default_nettype wire

// ===== bench/spi_port_properties.sv
// link checks between the port and its far end
`timescale 1ns/1ps
`default_nettype none
module spi_port_properties (
	input wire logic clk,
	input wire logic nrst,
	input wire logic dev_sck_o,
	input wire logic dev_sck_oe,
	input wire logic dev_mosi_oe,
	input wire logic dev_miso_oe,
	input wire logic far_sck_o,
	input wire logic far_sck_oe,
	input wire logic far_mosi_oe,
	input wire logic far_miso_oe,
	input wire logic far_ss_n_oe,
	input wire logic ss_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	property p_sck_one;
		!(dev_sck_oe && far_sck_oe);
	endproperty
	a_sck_one: assert property (p_sck_one)
		else $error("two clock drivers");
	property p_mosi_one;
		!(dev_mosi_oe && far_mosi_oe);
	endproperty
	a_mosi_one: assert property (p_mosi_one)
		else $error("two master-out drivers");
	property p_miso_one;
		!(dev_miso_oe && far_miso_oe);
	endproperty
	a_miso_one: assert property (p_miso_one)
		else $error("two master-in drivers");
	property p_master_pair;
		dev_mosi_oe |-> dev_sck_oe;
	endproperty
	a_master_pair: assert property (p_master_pair)
		else $error("data out without clock");
	property p_slave_out;
		dev_miso_oe |-> !dev_sck_oe;
	endproperty
	a_slave_out: assert property (p_slave_out)
		else $error("master drives its input line");
	// device clock half period is at least eight cycles
	property p_dev_half;
		$changed(dev_sck_o) && dev_sck_oe && $past(dev_sck_oe)
			|=> $stable(dev_sck_o)[*7];
	endproperty
	a_dev_half: assert property (p_dev_half)
		else $error("device clock half period short");
	property p_far_half;
		$changed(far_sck_o) && far_sck_oe && $past(far_sck_oe)
			|=> $stable(far_sck_o)[*8];
	endproperty
	a_far_half: assert property (p_far_half)
		else $error("far clock half period short");
	property p_far_ss_drive;
		far_sck_oe |-> far_ss_n_oe;
	endproperty
	a_far_ss_drive: assert property (p_far_ss_drive)
		else $error("far master leaves select undriven");
	property p_far_select;
		$changed(far_sck_o) && far_sck_oe && $past(far_sck_oe)
			|-> $past(ss_n) == 1'b0;
	endproperty
	a_far_select: assert property (p_far_select)
		else $error("clock edge without select");
	c_dev_clock: cover property (dev_sck_oe && $rose(dev_sck_o));
	c_far_clock: cover property (far_sck_oe && $rose(far_sck_o));
	c_slave_out: cover property ($rose(dev_miso_oe));
endmodule // spi_port_properties
`default_nettype wire

// ===== bench/tb.sv
// self-checking bench: device and far end joined by the link
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0] paddr, tx_byte, rx_byte;
	logic [31:0] pwdata, prdata;
	logic master_mode, cpol, cpha, slave_select, start, done, busy;
	int failures, num_checks;
	logic [7:0] exp_q[$];
	spi_link_if spi_link_if_i (); // separate data wires: full duplex
	spi_port_device spi_port_device_i (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.link(spi_link_if_i.dev));
	spi_port_far #(.HALF_CYC(10)) spi_port_far_i (.clk(clk), .nrst(nrst),
		.master_mode(master_mode), .cpol(cpol), .cpha(cpha),
		.slave_select(slave_select), .start(start), .tx_byte(tx_byte),
		.rx_byte(rx_byte), .done(done), .busy(busy),
		.link(spi_link_if_i.far));
	spi_port_properties spi_port_properties_i (.clk(clk), .nrst(nrst),
		.dev_sck_o(spi_link_if_i.dev_sck_o),
		.dev_sck_oe(spi_link_if_i.dev_sck_oe),
		.dev_mosi_oe(spi_link_if_i.dev_mosi_oe),
		.dev_miso_oe(spi_link_if_i.dev_miso_oe),
		.far_sck_o(spi_link_if_i.far_sck_o),
		.far_sck_oe(spi_link_if_i.far_sck_oe),
		.far_mosi_oe(spi_link_if_i.far_mosi_oe),
		.far_miso_oe(spi_link_if_i.far_miso_oe),
		.far_ss_n_oe(spi_link_if_i.far_ss_n_oe),
		.ss_n(spi_link_if_i.ss_n));

	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d failures=%0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic apb(input logic wr_en, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] rdat, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr_en;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// only the watchdog ends a wait for the answer
		while (pready !== 1'b1) @(posedge clk);
		rdat = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r;
		logic e;
		apb(1'b0, a, 8'h00, r, e);
		check_byte(r, exp);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic far_load(input logic [7:0] f);
		tx_byte <= f;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
	endtask
	// bounded wait on the far end, then time for the device filters
	task automatic wait_far();
		int n;
		for (n = 0; n < 2000 && done !== 1'b1; n++) @(posedge clk);
		if (n == 2000) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		end
		repeat (20) @(posedge clk);
	endtask

	// every byte the far end finishes must have been noted beforehand
	always @(posedge clk) begin
		if (nrst === 1'b1 && done === 1'b1) begin
			if (exp_q.size() == 0) check_byte(rx_byte, ~rx_byte);
			else check_byte(rx_byte, exp_q.pop_front());
		end
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#100000;
		failures++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
		finish_test();
	end
	initial begin
		logic [7:0] a, b, c, r;
		logic e;
		int m;
		{nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		{master_mode, cpol, cpha, slave_select, start, tx_byte} = '0;
		void'($urandom(32'h1a8d));
		repeat (5) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		rd(8'h00, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h08, 8'h00);
		apb(1'b0, 8'h0C, 8'h00, r, e);
		check_byte({7'h00, e}, 8'h01);
		check_byte(r, 8'h00);
		$display("test reset done");
		slave_select <= 1'b1;
		for (m = 0; m < 4; m++) begin
			cpol <= m[1];
			cpha <= m[0];
			wr(8'h00, 8'hD1 | 8'(m << 2));
			a = 8'($urandom);
			b = 8'($urandom);
			far_load(b);
			exp_q.push_back(a);
			wr(8'h08, a);
			wait_far();
			check_byte({7'h00, irq}, 8'h01);
			rd(8'h04, 8'h80);
			rd(8'h08, b);
			rd(8'h04, 8'h00);
			check_byte({7'h00, irq}, 8'h00);
		end
		$display("test modes done");
		a = 8'($urandom);
		b = 8'($urandom);
		c = 8'($urandom);
		far_load(b);
		exp_q.push_back(a);
		wr(8'h08, a);
		wr(8'h08, c);
		wait_far();
		wr(8'h08, c);
		repeat (300) @(posedge clk);
		rd(8'h04, 8'hC0);
		rd(8'h08, b);
		rd(8'h04, 8'h00);
		$display("test collision done");
		// far end settles its idle clock level before it takes the line
		{cpol, cpha, slave_select} <= 3'b000;
		wr(8'h00, 8'h40);
		master_mode <= 1'b1;
		wr(8'h08, c);
		exp_q.push_back(c);
		far_load(a);
		wait_far();
		// output released: the far master reads the line's pull level
		wr(8'h04, 8'h04);
		exp_q.push_back(8'hFF);
		far_load(b);
		wait_far();
		rd(8'h04, 8'hA4);
		rd(8'h04, 8'h84);
		rd(8'h08, a);
		wr(8'h04, 8'h00);
		master_mode <= 1'b0;
		$display("test overrun done");
		wr(8'h00, 8'h50);
		wr(8'h04, 8'h02);
		repeat (8) @(posedge clk);
		rd(8'h04, 8'h12);
		rd(8'h00, 8'h00);
		wr(8'h00, 8'h00);
		rd(8'h04, 8'h02);
		$display("test mode fault done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
